// file: tcou_compare.sv
`timescale 1ns/1ps

module tcou_compare
    import tcou_pkg::*;
#(
    parameter int unsigned CNT_W = TCOU_CNT_W
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Compare operands
    input wire logic [CNT_W-1:0] i_compare_value_pair,
    input wire logic [CNT_W-1:0] i_timer_count_pair,
    input wire logic i_timer_tick,
    // Control
    input wire logic [TCOU_MODE_W-1:0] i_compare_control_mode,
    input wire logic i_flag_clr,
    input wire logic i_pin_direction_bit,
    // Pin and status
    output logic o_compare_output_pin,
    output logic o_compare_output_oe,
    output logic o_compare_match_flag,
    output logic o_timer_rst
);

    // ========================================
    // Internal signals

    // Decoded mode
    tcou_act_t act;
    logic timer_rst_en;
    logic act_valid;

    // Match detection
    logic [CNT_W-1:0] bit_eq;
    logic match;
    logic match_q;
    logic match_rise;
    logic hit;

    // Action strobes
    logic hit_toggle;
    logic hit_set;
    logic hit_clear;
    logic hit_pulse;
    logic hit_swint;

    // Pin and pulse state
    logic pin_q;
    logic pin_d;
    logic pulse_q;
    logic pulse_d;
    logic pulse_end;

    // Flag and timer reset
    logic flag_q;
    logic flag_d;
    logic trst_q;
    logic trst_d;

    // ========================================
    // Mode decode
    // Each unit has its own decoder instance of the same module, so all units act alike
    tcou_mode_dec u_dec (
        .i_mode(i_compare_control_mode),
        .o_act(act),
        .o_timer_rst_en(timer_rst_en)
    );

    // Off and unused codes decode to no action, so they never act
    assign act_valid = (act != TCOU_ACT_NONE);

    // ========================================
    // Match detection
    // One comparator per bit over the full width;
    // a narrower check would alias distant counts
    for (genvar b = 0; b < CNT_W; b++) begin : g_bit_eq
        assign bit_eq[b] = (i_compare_value_pair[b] == i_timer_count_pair[b]);
    end

    // Whole-word equality
    assign match = &bit_eq;

    // Previous equality
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match;
        end
    end

    // A match held over many cycles acts once, on its first cycle
    assign match_rise = match && !match_q;

    // Rising match in a mode that acts
    assign hit = match_rise && act_valid;

    // ========================================
    // Action strobes
    // One strobe per action keeps the next-state logic flat;
    // exactly one of them is high on a hit
    assign hit_toggle = hit && (act == TCOU_ACT_TOGGLE);
    assign hit_set = hit && (act == TCOU_ACT_SET);
    assign hit_clear = hit && (act == TCOU_ACT_CLEAR);
    assign hit_pulse = hit && (act == TCOU_ACT_PULSE);
    assign hit_swint = hit && (act == TCOU_ACT_SWINT);

    // ========================================
    // Pin level
    // A pending pulse ends at the first timer tick after its match
    assign pulse_end = pulse_q && i_timer_tick;

    // Next pin level; a new toggle, set, clear or pulse match outranks the end of an older pulse,
    // and a software-interrupt match leaves the level alone
    always_comb begin
        pin_d = pin_q;
        if (hit_toggle) begin
            pin_d = !pin_q;
        end else if (hit_set || hit_pulse) begin
            pin_d = 1'b1;
        end else if (hit_clear) begin
            pin_d = 1'b0;
        end else if (pulse_end) begin
            pin_d = 1'b0;
        end else if (hit_swint) begin
            pin_d = pin_q;
        end
    end

    // Pin register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_q <= TCOU_PIN_RST;
        end else begin
            pin_q <= pin_d;
        end
    end

    // ========================================
    // Pulse timing
    // Pending from the pulse match to the next tick; a later pin action
    // cancels it, so an old pulse never undoes a newer set
    always_comb begin
        pulse_d = pulse_q;
        if (hit_pulse) begin
            pulse_d = 1'b1;
        end else if (hit_toggle || hit_set || hit_clear || i_timer_tick) begin
            pulse_d = 1'b0;
        end
    end

    // Pulse register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
        end
    end

    // ========================================
    // Match flag
    // Set wins over a clear in the same cycle,
    // so a match that lands during a clear is never lost
    always_comb begin
        flag_d = flag_q;
        if (hit) begin
            flag_d = 1'b1;
        end else if (i_flag_clr) begin
            flag_d = 1'b0;
        end
    end

    // Flag register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_q <= TCOU_FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ========================================
    // Timer reset
    // A one-cycle request; the timer owner clears its count on it.
    // No second request follows before the operands part again
    assign trst_d = hit && timer_rst_en;

    // Timer reset register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trst_q <= 1'b0;
        end else begin
            trst_q <= trst_d;
        end
    end

    // ========================================
    // Outputs
    // Pin level, registered so the pad never sees decode glitches
    assign o_compare_output_pin = pin_q;

    // Driver enabled only while software has made the pin an output
    assign o_compare_output_oe = !i_pin_direction_bit;

    // Sticky match flag
    assign o_compare_match_flag = flag_q;

    // One-cycle timer reset request
    assign o_timer_rst = trst_q;

endmodule : tcou_compare

// file: tcou_pkg.sv
package tcou_pkg;

    // ========================================
    // Widths
    localparam int unsigned TCOU_CNT_W = 16;
    localparam int unsigned TCOU_MODE_W = 4;

    // ========================================
    // Compare mode codes in the control field
    localparam logic [3:0] TCOU_MODE_OFF = 4'h0;
    localparam logic [3:0] TCOU_MODE_TOG_RST = 4'h1;
    localparam logic [3:0] TCOU_MODE_TOGGLE = 4'h2;
    localparam logic [3:0] TCOU_MODE_PULSE_RST = 4'h3;
    localparam logic [3:0] TCOU_MODE_SET = 4'h8;
    localparam logic [3:0] TCOU_MODE_CLEAR = 4'h9;
    localparam logic [3:0] TCOU_MODE_SWINT = 4'hA;
    localparam logic [3:0] TCOU_MODE_PULSE = 4'hB;

    // ========================================
    // Reset values
    localparam logic TCOU_PIN_RST = 1'b0;
    localparam logic TCOU_FLAG_RST = 1'b0;

    // Action decoded from the mode field
    typedef enum logic [2:0] {
        TCOU_ACT_NONE,
        TCOU_ACT_TOGGLE,
        TCOU_ACT_SET,
        TCOU_ACT_CLEAR,
        TCOU_ACT_PULSE,
        TCOU_ACT_SWINT
    } tcou_act_t;

endpackage : tcou_pkg

// file: tcou_mode_dec.sv
`timescale 1ns/1ps

// Decodes the four-bit mode field into a pin action and a timer reset request
module tcou_mode_dec
    import tcou_pkg::*;
(
    // Mode field
    input wire logic [TCOU_MODE_W-1:0] i_mode,
    // Decoded action
    output tcou_act_t o_act,
    output logic o_timer_rst_en
);

    // ========================================
    // Decode; unlisted codes do nothing so other units' modes stay inert here
    always_comb begin
        o_act = TCOU_ACT_NONE;
        o_timer_rst_en = 1'b0;
        case (i_mode)
            TCOU_MODE_TOG_RST: begin
                o_act = TCOU_ACT_TOGGLE;
                o_timer_rst_en = 1'b1;
            end
            TCOU_MODE_TOGGLE: o_act = TCOU_ACT_TOGGLE;
            TCOU_MODE_PULSE_RST: begin
                o_act = TCOU_ACT_PULSE;
                o_timer_rst_en = 1'b1;
            end
            TCOU_MODE_SET: o_act = TCOU_ACT_SET;
            TCOU_MODE_CLEAR: o_act = TCOU_ACT_CLEAR;
            TCOU_MODE_SWINT: o_act = TCOU_ACT_SWINT;
            TCOU_MODE_PULSE: o_act = TCOU_ACT_PULSE;
            default: o_act = TCOU_ACT_NONE;
        endcase
    end

endmodule : tcou_mode_dec

// file: tcou_cmp_sva.sv
`timescale 1ns/1ps
// ====
// Compare unit checker
module tcou_cmp_sva
    import tcou_pkg::*;
#(
    parameter int unsigned CNT_W = TCOU_CNT_W
) (
    // Design ports
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [CNT_W-1:0] i_compare_value_pair,
    input wire logic [CNT_W-1:0] i_timer_count_pair,
    input wire logic [TCOU_MODE_W-1:0] i_compare_control_mode,
    input wire logic i_timer_tick,
    input wire logic i_flag_clr,
    input wire logic o_compare_output_pin,
    input wire logic o_compare_match_flag,
    input wire logic o_timer_rst
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Only a fresh equality acts, so a held match is counted once
    wire eq = i_compare_value_pair == i_timer_count_pair;
    wire [3:0] m = i_compare_control_mode;
    wire p = o_compare_output_pin;
    logic eq_q;
    wire hit = eq && !eq_q && (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
    // Previous equality
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) eq_q <= 1'b0;
        else eq_q <= eq;
    end
    // Pulse pending from its match to the next tick; a later pin action cancels it
    logic pend_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) pend_q <= 1'b0;
        else if (hit && m inside {4'h3, 4'hB}) pend_q <= 1'b1;
        else if (i_timer_tick || (hit && m != 4'hA)) pend_q <= 1'b0;
    end
    flag_on_hit_a: assert property (hit |=> o_compare_match_flag) else $error("flag");
    pin_toggle_a: assert property (hit && m inside {4'h1, 4'h2} |=> p != $past(p)) else $error("toggle");
    pin_set_a: assert property (hit && m == 4'h8 |=> p) else $error("set");
    pin_clear_a: assert property (hit && m == 4'h9 |=> !p) else $error("clear");
    swint_keep_a: assert property (hit && m == 4'hA && !(pend_q && i_timer_tick) |=> $stable(p))
        else $error("swint");
    timer_rst_a: assert property (hit && m inside {4'h1, 4'h3} |=> o_timer_rst ##1 !o_timer_rst)
        else $error("trst");
    pulse_end_a: assert property (pend_q && i_timer_tick && !hit |=> !p) else $error("pulse end");
    flag_clear_a: assert property (i_flag_clr && !hit |=> !o_compare_match_flag) else $error("clr");
    flag_only_hit_a: assert property ($rose(o_compare_match_flag) |-> $past(hit)) else $error("src");
    pulse_high_a: assert property (hit && m inside {4'h3, 4'hB} |=> p) else $error("pulse");
endmodule : tcou_cmp_sva

// file: tcou_pin_load.sv
`timescale 1ns/1ps
// ====
// Load on the pin; a released pin is pulled low
module tcou_pin_load (
    // Pin
    input wire logic i_pin,
    input wire logic i_oe,
    output logic o_lvl
);
    assign o_lvl = i_oe ? i_pin : 1'b0;
endmodule : tcou_pin_load

// file: tcou_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("MISMATCH %0t bad value", $time); end end
// ====
// Bench
module tb;
    logic clk = 0, rst_n = 0, tick = 0, fc = 0, dir = 0, ep = 0, ef = 0, pin, oe, flag, trst, lvl;
    logic [15:0] cv = 16'h0000, tc = 16'h0001, v;
    logic [3:0] m, md = 4'h0;
    logic [3:0] modes [9] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'h4, 4'h2};
    int errors = 0, compares = 0;
    tcou_compare i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_compare_value_pair(cv), .i_timer_count_pair(tc),
        .i_timer_tick(tick), .i_compare_control_mode(md), .i_flag_clr(fc), .i_pin_direction_bit(dir),
        .o_compare_output_pin(pin), .o_compare_output_oe(oe), .o_compare_match_flag(flag), .o_timer_rst(trst));
    tcou_pin_load i_load (.i_pin(pin), .i_oe(oe), .o_lvl(lvl));
    // Clock
    initial forever #20 clk = ~clk;
    task stop_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    // Each pass: miss, hit, leave; then a timer tick and a flag clear
    initial begin
        void'($urandom(19362));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 18; k++) begin
            m = modes[k % 9];
            v = 16'($urandom);
            @(posedge clk); md <= m; cv <= v; tc <= v - 16'h0001; fc <= k[0];
            dir <= (k % 4 == 3);
            @(posedge clk); tc <= v;
            @(posedge clk); tc <= v + 16'h0001;
            if (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB}) ef = 1'b1;
            if (m inside {4'h1, 4'h2}) ep = !ep;
            if (m inside {4'h3, 4'h8, 4'hB}) ep = 1'b1;
            if (m == 4'h9) ep = 1'b0;
            #1 `CHK(flag, ef)
            `CHK(lvl, dir ? 1'b0 : ep)
            `CHK(oe, !dir)
            `CHK(trst, m == 4'h1 || m == 4'h3)
            @(posedge clk); tick <= 1'b1; fc <= 1'b1;
            @(posedge clk); tick <= 1'b0;
            if (m inside {4'h3, 4'hB}) ep = 1'b0;
            ef = 1'b0;
            #1 `CHK(pin, ep)
            `CHK(flag, ef)
        end
        stop_test();
    end
endmodule : tb
bind tcou_compare tcou_cmp_sva #(.CNT_W(CNT_W)) u_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_compare_value_pair(i_compare_value_pair), .i_timer_count_pair(i_timer_count_pair),
    .i_compare_control_mode(i_compare_control_mode), .i_timer_tick(i_timer_tick), .i_flag_clr(i_flag_clr),
    .o_compare_output_pin(o_compare_output_pin), .o_compare_match_flag(o_compare_match_flag),
    .o_timer_rst(o_timer_rst));
